// [verilog/aad_pkg.sv]
// Purpose: shared constants, opcodes and types of the accumulator alu decoder
// Assumes: 8-bit data, 12-bit program counter
// Notes:   call encodes the address low nibble in the opcode high nibble
`default_nettype none
package aad_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths and sizes
	localparam int PC_W        = 12;
	localparam int DATA_W      = 8;
	localparam int STACK_DEPTH = 6;
	localparam int CYCLES_LONG = 4;

	////////////////////////////////////////////////////////////////////////
	// opcodes and operand codes
	localparam logic [7:0] OP_ADD_REG   = 8'h5f;
	localparam logic [7:0] OP_ADD_IND_X = 8'h47;
	localparam logic [7:0] OP_ADD_IND_Y = 8'h4f;
	localparam logic [7:0] OP_ADD_IMM   = 8'h57;
	localparam logic [7:0] OP_AND_REG   = 8'hbf;
	localparam logic [7:0] OP_AND_IND_X = 8'ha7;
	localparam logic [7:0] OP_AND_IND_Y = 8'haf;
	localparam logic [7:0] OP_AND_IMM   = 8'hb7;
	localparam logic [7:0] OP_CMP_REG   = 8'h3f;
	localparam logic [7:0] OP_CMP_IND_X = 8'h27;
	localparam logic [7:0] OP_CMP_IND_Y = 8'h2f;
	localparam logic [7:0] OP_CLR_ACC   = 8'hdf;
	localparam logic [7:0] OP_CLR_MEM   = 8'h0d;
	localparam logic [7:0] OP_COM       = 8'h2d;
	localparam logic [7:0] OP_RET       = 8'hcd;
	localparam logic [3:0] OP_CALL_LO   = 4'h1;
	localparam logic [7:0] SRC_ACC      = 8'hff;
	localparam logic [7:0] ADDR_PTR_X   = 8'h80;
	localparam logic [7:0] ADDR_PTR_Y   = 8'h81;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [PC_W-1:0]   PC_RESET  = 12'h000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [3:0] {
		AAD_K_NONE, AAD_K_ADD, AAD_K_AND, AAD_K_CMP, AAD_K_SUM_IMMEDIATE, AAD_K_CONJUNCTION_IMMEDIATE,
		AAD_K_CALL, AAD_K_RET, AAD_K_CLRA, AAD_K_CLRM, AAD_K_COM
	} aad_kind_t;

	typedef enum logic [1:0] {
		AAD_M_REG, AAD_M_IND, AAD_M_IMM, AAD_M_INH
	} aad_mode_t;

	////////////////////////////////////////////////////////////////////////
	// opcode to operation
	function automatic aad_kind_t aad_kind(input logic [7:0] op);
		aad_kind_t k;
		k = AAD_K_NONE;
		unique case (op)
			OP_ADD_REG, OP_ADD_IND_X, OP_ADD_IND_Y: k = AAD_K_ADD;
			OP_AND_REG, OP_AND_IND_X, OP_AND_IND_Y: k = AAD_K_AND;
			OP_CMP_REG, OP_CMP_IND_X, OP_CMP_IND_Y: k = AAD_K_CMP;
			OP_ADD_IMM: k = AAD_K_SUM_IMMEDIATE;
			OP_AND_IMM: k = AAD_K_CONJUNCTION_IMMEDIATE;
			OP_CLR_ACC: k = AAD_K_CLRA;
			OP_CLR_MEM: k = AAD_K_CLRM;
			OP_COM:     k = AAD_K_COM;
			OP_RET:     k = AAD_K_RET;
			default:    k = (op[3:0] == OP_CALL_LO) ? AAD_K_CALL : AAD_K_NONE;
		endcase
		return k;
	endfunction : aad_kind

	// opcode to addressing mode
	function automatic aad_mode_t aad_mode(input logic [7:0] op);
		aad_mode_t m;
		m = AAD_M_INH;
		unique case (op)
			OP_ADD_REG, OP_AND_REG, OP_CMP_REG, OP_CLR_ACC, OP_CLR_MEM: m = AAD_M_REG;
			OP_ADD_IND_X, OP_ADD_IND_Y, OP_AND_IND_X, OP_AND_IND_Y,
			OP_CMP_IND_X, OP_CMP_IND_Y: m = AAD_M_IND;
			OP_ADD_IMM, OP_AND_IMM: m = AAD_M_IMM;
			default: m = AAD_M_INH;
		endcase
		return m;
	endfunction : aad_mode

endpackage : aad_pkg
`default_nettype wire

// [verilog/aad_return_stack.sv]
// Purpose: return address stack of fixed depth
// Assumes: push and pop never in the same cycle
// Notes:   a push when full is dropped, so the oldest entries survive
`timescale 1ns/1ps
`default_nettype none
module aad_return_stack #(
	parameter int DEPTH = aad_pkg::STACK_DEPTH,
	parameter int WIDTH = aad_pkg::PC_W
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] push_data,
	output logic      [WIDTH-1:0] top,
	output logic                  full
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	logic [WIDTH-1:0] entry [DEPTH];
	logic [CW-1:0]    count;
	logic [CW-1:0]    top_idx;

	////////////////////////////////////////////////////////////////////////
	// top index; an empty stack still answers with the bottom entry
	assign full    = (count == DEPTH_C);
	assign top_idx = (count == '0) ? '0 : count - CW'(1);
	assign top     = entry[top_idx];

	// occupancy; overflow pushes are lost, not wrapped
	always_ff @(posedge clk) begin
		if (reset)
			count <= '0;
		else if (push && !full) // RQ10
			count <= count + CW'(1);
		else if (pop && count != '0) // RQ11
			count <= count - CW'(1);
	end

	// storage, one flip-flop row per level
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_lvl
			always_ff @(posedge clk) begin
				if (reset)
					entry[i] <= '0;
				else if (push && count == CW'(i)) // RQ10
					entry[i] <= push_data;
			end
		end
	endgenerate
endmodule : aad_return_stack
`default_nettype wire

// [verilog/aad_core.sv]
// Purpose: decode and execute of add, and, compare, clear, complement,
//          call and return for an 8-bit accumulator core
// Assumes: program memory and data space answer in the same cycle
// Notes:   accumulator is held here; working registers live in data space
//
// Contract
// RQ1: register add sums into accumulator, source kept
// RQ2: 5F prefix, FF acc, 80-83 regs
// RQ3: 47 and 4F indirect add, four cycles
// RQ4: add clears carry, sets on overflow; zero
// RQ5: 57 nn immediate add into accumulator
// RQ6: and into accumulator, carry kept, zero
// RQ7: BF prefix and, A7 AF indirect
// RQ8: B7 nn immediate and, carry kept
// RQ9: call pushes pc, loads twelve bit target
// RQ10: six level stack, overflow pushes lost
// RQ11: return pops top into pc
// RQ12: DF FF clears accumulator, sets both flags
// RQ13: 0D rr 00 clears location, flags kept
// RQ14: complement, carry from old msb, zero
// RQ15: compare sets flags, accumulator kept
// RQ16: compare carry when accumulator below source
// RQ17: 3F prefix compare, 27 2F indirect
// RQ18: indirect operand from pointer's data address
`timescale 1ns/1ps
`default_nettype none
module aad_core #(
	parameter int STACK_DEPTH = aad_pkg::STACK_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        reset,
	output logic      [11:0] pm_addr,
	input  wire logic [7:0]  pm_data,
	output logic      [7:0]  ds_addr,
	input  wire logic [7:0]  ds_rdata,
	output logic      [7:0]  ds_wdata,
	output logic             ds_we,
	output logic      [11:0] pc,
	output logic      [7:0]  acc,
	output logic             zero_flag,
	output logic             carry_flag,
	output logic             instr_done,
	output logic             stack_full
);
	typedef enum logic [1:0] {AAD_S_FETCH, AAD_S_ARG, AAD_S_OPER, AAD_S_EXEC} aad_state_t;

	aad_state_t          state;
	aad_state_t          next_state;
	logic [7:0]          opcode;
	logic [7:0]          arg;
	logic [7:0]          operand;
	aad_pkg::aad_kind_t  kind;
	aad_pkg::aad_mode_t  mode;
	aad_pkg::aad_kind_t  fetch_kind;
	logic                ptr_sel_y;
	logic                exec;

	////////////////////////////////////////////////////////////////////////
	// decode of the latched opcode and of the byte on the bus
	assign kind       = aad_pkg::aad_kind(opcode);
	assign mode       = aad_pkg::aad_mode(opcode);
	assign fetch_kind = aad_pkg::aad_kind(pm_data);
	assign ptr_sel_y  = opcode[3]; // RQ3 RQ7 RQ17
	assign exec       = (state == AAD_S_EXEC);

	// sequence: return takes two cycles, everything else four
	always_comb begin
		next_state = AAD_S_FETCH;
		unique case (state)
			AAD_S_FETCH: next_state = (fetch_kind == aad_pkg::AAD_K_RET) ? AAD_S_EXEC : AAD_S_ARG; // RQ11
			AAD_S_ARG:   next_state = AAD_S_OPER;
			AAD_S_OPER:  next_state = AAD_S_EXEC;
			AAD_S_EXEC:  next_state = AAD_S_FETCH;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset)
			state <= AAD_S_FETCH;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// bus addressing per cycle
	logic [11:0] pc_plus1;
	logic [11:0] pc_plus2;
	logic        arg_is_acc;
	logic        clr_third;
	assign pc_plus1   = pc + 12'h001;
	assign pc_plus2   = pc + 12'h002;
	assign arg_is_acc = (arg == aad_pkg::SRC_ACC); // RQ2
	assign clr_third  = (kind == aad_pkg::AAD_K_CLRM);

	// third byte only fetched by the memory clear form
	assign pm_addr = (state == AAD_S_FETCH) ? pc :
			 (state == AAD_S_OPER && clr_third) ? pc_plus2 : pc_plus1; // RQ13

	// indirect: pointer first, then the location it names
	assign ds_addr = (state == AAD_S_ARG) ?
			 (ptr_sel_y ? aad_pkg::ADDR_PTR_Y : aad_pkg::ADDR_PTR_X) : arg; // RQ18

	// memory clear writes zero in the execute cycle; flags untouched
	assign ds_we    = exec && clr_third && !arg_is_acc; // RQ13
	assign ds_wdata = aad_pkg::ZERO_BYTE; // RQ13

	////////////////////////////////////////////////////////////////////////
	// instruction byte latches
	always_ff @(posedge clk) begin
		if (reset)
			opcode <= 8'h00;
		else if (state == AAD_S_FETCH)
			opcode <= pm_data;
	end

	// second byte: operand address, immediate, or pointer value
	always_ff @(posedge clk) begin
		if (reset)
			arg <= 8'h00;
		else if (state == AAD_S_ARG)
			arg <= (mode == aad_pkg::AAD_M_IND) ? ds_rdata : pm_data; // RQ18
	end

	// operand; immediates reuse the second byte
	always_ff @(posedge clk) begin
		if (reset)
			operand <= 8'h00;
		else if (state == AAD_S_OPER)
			operand <= (mode == aad_pkg::AAD_M_IMM) ? arg : ds_rdata; // RQ5 RQ8
	end

	////////////////////////////////////////////////////////////////////////
	// arithmetic; register form with FF reads the accumulator itself
	logic [7:0] src;
	logic [8:0] sum9;
	logic [8:0] diff9;
	logic [7:0] and8;
	logic [7:0] inv8;
	assign src   = (mode == aad_pkg::AAD_M_REG && arg_is_acc) ? acc : operand; // RQ2
	assign sum9  = {1'b0, acc} + {1'b0, src}; // RQ1 RQ4
	assign diff9 = {1'b0, acc} - {1'b0, src}; // RQ15
	assign and8  = acc & src; // RQ6
	assign inv8  = ~acc; // RQ14

	// results per operation, flags kept unless the operation owns them
	logic [7:0] next_acc;
	logic       next_zero;
	logic       next_carry;
	always_comb begin
		next_acc   = acc;
		next_zero  = zero_flag;
		next_carry = carry_flag;
		unique case (kind)
			aad_pkg::AAD_K_ADD, aad_pkg::AAD_K_SUM_IMMEDIATE: begin
				next_acc   = sum9[7:0]; // RQ1 RQ5
				next_carry = sum9[8]; // RQ4
				next_zero  = (sum9[7:0] == 8'h00); // RQ4
			end
			aad_pkg::AAD_K_AND, aad_pkg::AAD_K_CONJUNCTION_IMMEDIATE: begin
				next_acc  = and8; // RQ6 RQ8
				next_zero = (and8 == 8'h00); // RQ6 RQ8
			end
			aad_pkg::AAD_K_CMP: begin
				next_carry = diff9[8]; // RQ16
				next_zero  = (diff9[7:0] == 8'h00); // RQ15
			end
			aad_pkg::AAD_K_CLRA: begin
				if (arg_is_acc) begin
					next_acc   = aad_pkg::ZERO_BYTE; // RQ12
					next_zero  = 1'b1; // RQ12
					next_carry = 1'b1; // RQ12
				end
			end
			aad_pkg::AAD_K_CLRM: begin
				// accumulator as a clear target: zeroed without flags
				if (arg_is_acc)
					next_acc = aad_pkg::ZERO_BYTE; // RQ13
			end
			aad_pkg::AAD_K_COM: begin
				next_acc   = inv8; // RQ14
				next_carry = acc[7]; // RQ14
				next_zero  = (inv8 == 8'h00); // RQ14
			end
			default: begin
				next_acc = acc;
			end
		endcase
	end

	// accumulator and flags commit only in the execute cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			acc        <= aad_pkg::ACC_RESET;
			zero_flag  <= 1'b0;
			carry_flag <= 1'b0;
		end else if (exec) begin
			acc        <= next_acc;
			zero_flag  <= next_zero;
			carry_flag <= next_carry;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter and return stack
	logic [11:0] call_target;
	logic [11:0] ret_addr;
	logic        do_push;
	logic        do_pop;
	logic [11:0] next_pc;
	assign call_target = {arg, opcode[7:4]}; // RQ9
	assign do_push     = exec && kind == aad_pkg::AAD_K_CALL; // RQ9
	assign do_pop      = exec && kind == aad_pkg::AAD_K_RET; // RQ11

	// return resumes after the call: push the address of the next byte pair
	always_comb begin
		next_pc = pc;
		if (exec) begin
			unique case (kind)
				aad_pkg::AAD_K_CALL: next_pc = call_target; // RQ9
				aad_pkg::AAD_K_RET:  next_pc = ret_addr; // RQ11
				aad_pkg::AAD_K_CLRM: next_pc = pc + 12'h003;
				aad_pkg::AAD_K_NONE, aad_pkg::AAD_K_COM: next_pc = pc_plus1;
				default: next_pc = (mode == aad_pkg::AAD_M_IND) ? pc_plus1 : pc_plus2; // RQ2 RQ3
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			pc <= aad_pkg::PC_RESET;
		else
			pc <= next_pc;
	end

	// overflowing pushes are dropped inside the stack
	aad_return_stack #(
		.DEPTH (STACK_DEPTH),
		.WIDTH (aad_pkg::PC_W)
	) u_stack (
		.clk       (clk),
		.reset     (reset),
		.push      (do_push), // RQ10
		.pop       (do_pop),
		.push_data (pc_plus2), // RQ9
		.top       (ret_addr),
		.full      (stack_full)
	);

	// one pulse per finished instruction
	always_ff @(posedge clk) begin
		if (reset)
			instr_done <= 1'b0;
		else
			instr_done <= exec;
	end
endmodule : aad_core
`default_nettype wire

// [testbench/aad_mem_model.sv]
// Purpose: program memory and data space seen by the core
// Assumes: same-cycle read answers
// Notes:   bench fills pm and ds directly
`timescale 1ns/1ps
`default_nettype none
module aad_mem_model (
	input  wire logic        clk,
	input  wire logic [11:0] pm_addr,
	output logic      [7:0]  pm_data,
	input  wire logic [7:0]  ds_addr,
	output logic      [7:0]  ds_rdata,
	input  wire logic [7:0]  ds_wdata,
	input  wire logic        ds_we
);
	logic [7:0] pm [4096];
	logic [7:0] ds [256];
	// combinational reads, no wait states
	assign pm_data  = pm[pm_addr];
	assign ds_rdata = ds[ds_addr];
	// write lands at the end of the strobe cycle
	always @(posedge clk) begin
		if (ds_we) begin
			ds[ds_addr] <= ds_wdata;
		end
	end
endmodule : aad_mem_model
`default_nettype wire

// [testbench/aad_core_props.sv]
// Purpose: port checker of the core
// Assumes: instr_done marks the fetch cycle of the next opcode
// Notes:   the opcode right after reset is not covered here
`timescale 1ns/1ps
`default_nettype none
module aad_core_props (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [11:0] pm_addr,
	input wire logic [7:0]  pm_data,
	input wire logic [7:0]  ds_addr,
	input wire logic [7:0]  ds_rdata,
	input wire logic [7:0]  ds_wdata,
	input wire logic        ds_we,
	input wire logic [11:0] pc,
	input wire logic [7:0]  acc,
	input wire logic        zero_flag,
	input wire logic        carry_flag,
	input wire logic        instr_done,
	input wire logic        stack_full
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// opcode tests sit on the fetch cycle
	property p_sum_imm;
		instr_done && pm_data == aad_pkg::OP_ADD_IMM |-> ##4 instr_done
			&& acc == 8'($past(acc, 4) + $past(pm_data, 3)) && zero_flag == (acc == 8'h00);
	endproperty
	property p_and_imm;
		instr_done && pm_data == aad_pkg::OP_AND_IMM |-> ##4
			acc == ($past(acc, 4) & $past(pm_data, 3)) && carry_flag == $past(carry_flag, 4);
	endproperty
	property p_invert;
		instr_done && pm_data == aad_pkg::OP_COM |-> ##4
			acc == ~$past(acc, 4) && carry_flag == ($past(acc, 4) > 8'h7f);
	endproperty
	property p_zero_acc;
		instr_done && pm_data == aad_pkg::OP_CLR_ACC ##1 pm_data == aad_pkg::SRC_ACC
			|-> ##3 acc == 8'h00 && zero_flag && carry_flag;
	endproperty
	property p_pop;
		instr_done && pm_data == aad_pkg::OP_RET |-> ##2 instr_done;
	endproperty
	property p_ind;
		instr_done && pm_data == aad_pkg::OP_ADD_IND_X |=> ds_addr == 8'h80
			##1 ds_addr == $past(ds_rdata) ##2 instr_done;
	endproperty
	property p_wdat;
		ds_we |-> ds_wdata == 8'h00 && ds_addr == $past(pm_data, 2);
	endproperty
	property p_wflg;
		ds_we |=> instr_done && $stable(zero_flag) && $stable(carry_flag)
			&& pc == $past(pc) + 12'h003;
	endproperty
	property p_done;
		instr_done |=> !instr_done;
	endproperty
	a_sum_imm: assert property (p_sum_imm) else $error("imm add wrong");
	a_and_imm: assert property (p_and_imm) else $error("imm and wrong");
	a_invert: assert property (p_invert) else $error("invert wrong");
	a_zero_acc: assert property (p_zero_acc) else $error("acc clear wrong");
	a_pop: assert property (p_pop) else $error("return length wrong");
	a_ind: assert property (p_ind) else $error("indirect wrong");
	a_wdat: assert property (p_wdat) else $error("clear write wrong");
	a_wflg: assert property (p_wflg) else $error("clear flags wrong");
	a_done: assert property (p_done) else $error("done too long");
	c_full: cover property (stack_full);
	c_we: cover property (ds_we);
	c_pop: cover property (instr_done && pm_data == aad_pkg::OP_RET);
endmodule : aad_core_props
bind aad_core aad_core_props chk_u (.clk(clk), .reset(reset), .pm_addr(pm_addr),
	.pm_data(pm_data), .ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata),
	.ds_we(ds_we), .pc(pc), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
	.instr_done(instr_done), .stack_full(stack_full));
`default_nettype wire

// [testbench/test_accumulator_alu_decode.sv]
// Purpose: self-checking bench of the core
// Assumes: memory model answers in the same cycle
// Notes:   results sampled at the falling edge of the done cycle
`timescale 1ns/1ps
`default_nettype none
module test_accumulator_alu_decode;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [11:0] pm_addr, pc;
	logic [7:0]  pm_data, ds_addr, ds_rdata, ds_wdata, acc;
	logic        ds_we, zero_flag, carry_flag, instr_done, stack_full;
	int          bad_count = 0;
	int          checks = 0;
	always #25 clk = ~clk;
	aad_core dut_u (.clk(clk), .reset(reset), .pm_addr(pm_addr), .pm_data(pm_data),
		.ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we),
		.pc(pc), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
		.instr_done(instr_done), .stack_full(stack_full));
	aad_mem_model mem_u (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
		.ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we));
	////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// hold reset, wipe memories, load program from 000; 00 is a no-op filler
	task automatic prog(input logic [7:0] b [$]);
		reset = 1'b1;
		for (int i = 0; i < 4096; i++) mem_u.pm[i] = 8'h00;
		for (int i = 0; i < 256; i++) mem_u.ds[i] = 8'h00;
		foreach (b[i]) mem_u.pm[i] = b[i];
		mem_u.ds[8'h80] = 8'h30;
		mem_u.ds[8'h81] = 8'h31;
	endtask : prog
	task automatic go();
		repeat (5) @(negedge clk);
		reset = 1'b0;
	endtask : go
	// bounded wait for the next done pulse
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (instr_done !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
	endtask : wait_done
	task automatic step(input logic [7:0] a, input logic z, input logic c);
		wait_done();
		check({acc, zero_flag, carry_flag}, {a, z, c});
	endtask : step
	////////////////////////////////////////
	task automatic t_add();
		prog({8'h57, 8'h20, 8'h5f, 8'h22, 8'h47, 8'h4f, 8'h5f, 8'hff});
		mem_u.ds[8'h22] = 8'h33;
		mem_u.ds[8'h30] = 8'hf0;
		mem_u.ds[8'h31] = 8'hbd;
		go();
		step(8'h20, 1'b0, 1'b0);
		step(8'h53, 1'b0, 1'b0);
		step(8'h43, 1'b0, 1'b1);
		step(8'h00, 1'b1, 1'b1);
		step(8'h00, 1'b1, 1'b0);
		check(mem_u.ds[8'h22], 8'h33);
		check(pc, 12'h008);
		$display("t_add done");
	endtask : t_add
	task automatic t_and();
		prog({8'h57, 8'hff, 8'h57, 8'hcd, 8'hbf, 8'h54, 8'hb7, 8'hc3, 8'haf, 8'ha7});
		mem_u.ds[8'h54] = 8'hf0;
		mem_u.ds[8'h30] = 8'h0f;
		mem_u.ds[8'h31] = 8'h40;
		go();
		step(8'hff, 1'b0, 1'b0);
		step(8'hcc, 1'b0, 1'b1);
		step(8'hc0, 1'b0, 1'b1);
		step(8'hc0, 1'b0, 1'b1);
		step(8'h40, 1'b0, 1'b1);
		step(8'h00, 1'b1, 1'b1);
		$display("t_and done");
	endtask : t_and
	task automatic t_cmp();
		prog({8'h57, 8'h50, 8'h3f, 8'h22, 8'h27, 8'h2f, 8'h3f, 8'hff});
		mem_u.ds[8'h22] = 8'h60;
		mem_u.ds[8'h30] = 8'h50;
		mem_u.ds[8'h31] = 8'h10;
		go();
		step(8'h50, 1'b0, 1'b0);
		step(8'h50, 1'b0, 1'b1);
		step(8'h50, 1'b1, 1'b0);
		step(8'h50, 1'b0, 1'b0);
		step(8'h50, 1'b1, 1'b0);
		$display("t_cmp done");
	endtask : t_cmp
	task automatic t_clear();
		prog({8'h57, 8'hb9, 8'hdf, 8'hff, 8'h57, 8'hb9, 8'h2d, 8'h0d, 8'h22, 8'h00, 8'h2d});
		mem_u.ds[8'h22] = 8'h33;
		go();
		step(8'hb9, 1'b0, 1'b0);
		step(8'h00, 1'b1, 1'b1);
		step(8'hb9, 1'b0, 1'b0);
		step(8'h46, 1'b0, 1'b1);
		step(8'h46, 1'b0, 1'b1);
		check(mem_u.ds[8'h22], 8'h00);
		step(8'hb9, 1'b0, 1'b0);
		$display("t_clear done");
	endtask : t_clear
	// seven nested calls; the seventh return address is lost
	task automatic t_call();
		prog({8'h01, 8'h10});
		for (int i = 1; i < 7; i++) begin
			mem_u.pm[12'(i * 256)] = 8'h01;
			mem_u.pm[12'(i * 256 + 1)] = 8'(16 * (i + 1));
		end
		mem_u.pm[12'h700] = aad_pkg::OP_RET;
		mem_u.pm[12'h502] = aad_pkg::OP_RET;
		go();
		for (int i = 0; i < 7; i++) begin
			wait_done();
			check(pc, 16'((i + 1) * 256));
			check(stack_full, 16'(i >= 5));
		end
		wait_done();
		check(pc, 12'h502);
		check(stack_full, 1'b0);
		wait_done();
		check(pc, 12'h402);
		$display("t_call done");
	endtask : t_call
	////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		t_add();
		t_and();
		t_cmp();
		t_clear();
		t_call();
		tally_and_finish();
	end
	// about 150 cycles expected; cut a hang well beyond that
	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
endmodule : test_accumulator_alu_decode
`default_nettype wire
